// ==== rtl/pkt_client_defs.svh ====
// register offsets, field positions, reset values for the packet client register bank
// assumes a 32-bit word bus; printed offsets are word indices, byte address is four times
`ifndef PKT_CLIENT_DEFS_SVH
`define PKT_CLIENT_DEFS_SVH

// ==========================================
// register indices and address width
`define IDX_CLIENT_IDENT       16'h1001
`define IDX_FEATURE_VECTOR     16'h1002
`define IDX_DIE_TEMPERATURE    16'h1006
`define IDX_TRAFFIC_GEN_CTRL   16'h1010
`define IDX_LOOPBACK_FIFO_ERR  16'h1015
`define IDX_LOOPBACK_SOFT_RST  16'h1016
`define ADDR_W                 18

// ==========================================
// field positions
`define GEN_DISABLE_BIT        1
`define GEN_LOOPBACK_BIT       3
`define ERR_UNDERFLOW_BIT      0
`define ERR_OVERFLOW_BIT       1
`define ERR_CLEAR_BIT          2

// ==========================================
// reset values and the feature vector zero mask
`define GEN_CTRL_RESET         4'h5
`define FIFO_ERR_RESET         3'h0
`define SOFT_RST_RESET         1'h0
`define GEN_DISABLE_RESET      1'b0
`define FEATURE_ZERO_MASK      10'h092

`endif

// ==== rtl/pkt_client_pkg.sv ====
// types for the packet client register bank
// assumes pkt_client_defs.svh for numeric constants
package pkt_client_pkg;
	// ==========================================
	// bus slave phase
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_DATA = 2'b10
	} bus_state_e;
	typedef logic [31:0] word_t;
endpackage

// ==== rtl/sticky_error_flags.sv ====
// sticky underflow and overflow flags with a common software clear
// assumes event inputs are synchronous to clk
module sticky_error_flags
	import pkt_client_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// events and clear
	input  wire logic       underflow_evt,
	input  wire logic       overflow_evt,
	input  wire logic       clear_req,
	// flags
	output logic      [1:0] flags_r
);
	// ==========================================
	// flag storage
	// set wins over clear so an event in the clear cycle is kept
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_r <= 2'h0;
		end else begin
			if (underflow_evt)
				flags_r[0] <= 1'b1;
			else if (clear_req)
				flags_r[0] <= 1'b0;
			if (overflow_evt)
				flags_r[1] <= 1'b1;
			else if (clear_req)
				flags_r[1] <= 1'b0;
		end
	end

	// ==========================================
	// checks
	chk_underflow_sticks: assert property (
		@(posedge clk) disable iff (rst)
		underflow_evt |=> flags_r[0]
	) else $error("underflow flag not set");

	chk_overflow_sticks: assert property (
		@(posedge clk) disable iff (rst)
		flags_r[1] && !clear_req |=> flags_r[1]
	) else $error("overflow flag lost");
endmodule // sticky_error_flags

// ==== rtl/pkt_client_regs.sv ====
// packet client control and status register bank, AHB-Lite slave
// assumes one clock, synchronous active-high reset, status inputs on clk
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "pkt_client_defs.svh"

module pkt_client_regs
	import pkt_client_pkg::*;
#(
	parameter logic [31:0] IDENT_WORD   = 32'h706b_636c, // arbitrary value
	parameter logic [9:0]  FEATURE_BITS = 10'h200
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// status from the datapath
	input  wire logic [7:0]  temp_code,
	input  wire logic        loopback_mode,
	input  wire logic        fifo_underflow,
	input  wire logic        fifo_overflow,
	// control to the datapath
	output logic             gen_disable,
	output logic             loopback_rst
);
	// ==========================================
	// state
	bus_state_e         state_r;
	logic               wr_pend_r;
	logic [15:0]        idx_r;
	logic [3:0]         gen_ctrl_r;
	logic               soft_rst_r;
	logic [1:0]         err_flags;
	logic               err_clear;
	logic [7:0]         temp_r;
	logic               loop_r;
	logic [31:0]        rdata_nxt;
	logic               take;

	function automatic logic [15:0] word_index(input logic [31:0] a);
		word_index = a[`ADDR_W-1:2];
	endfunction

	// true for the six implemented word indices
	function automatic logic reg_mapped(input logic [15:0] idx);
		case (idx)
			`IDX_CLIENT_IDENT, `IDX_FEATURE_VECTOR, `IDX_DIE_TEMPERATURE,
			`IDX_TRAFFIC_GEN_CTRL, `IDX_LOOPBACK_FIFO_ERR, `IDX_LOOPBACK_SOFT_RST:
				reg_mapped = 1'b1;
			default:
				reg_mapped = 1'b0;
		endcase
	endfunction

	assign take = hsel && hready && htrans[1];

	// ==========================================
	// address phase capture
	// every transfer completes without wait states, response always okay
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r   <= ST_IDLE;
			wr_pend_r <= 1'b0;
			idx_r     <= 16'h0;
		end else begin
			case (state_r)
				ST_IDLE, ST_DATA: begin
					state_r   <= take ? ST_DATA : ST_IDLE;
					wr_pend_r <= take && hwrite;
					idx_r     <= take ? word_index(haddr) : idx_r;
				end
				default: begin
					state_r   <= ST_IDLE;
					wr_pend_r <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ==========================================
	// writable registers
	// only bit 1 is writable; reserved bits keep reset value, bit 3 is status
	always_ff @(posedge clk) begin
		if (rst) begin
			gen_ctrl_r <= `GEN_CTRL_RESET;
		end else if (wr_pend_r && idx_r == `IDX_TRAFFIC_GEN_CTRL) begin
			gen_ctrl_r[`GEN_DISABLE_BIT] <= hwdata[`GEN_DISABLE_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			soft_rst_r <= `SOFT_RST_RESET;
		end else if (wr_pend_r && idx_r == `IDX_LOOPBACK_SOFT_RST) begin
			soft_rst_r <= hwdata[0];
		end
	end

	// clear is a one-cycle pulse from the write; bit 2 never stores
	assign err_clear = wr_pend_r && idx_r == `IDX_LOOPBACK_FIFO_ERR
		&& hwdata[`ERR_CLEAR_BIT];

	sticky_error_flags u_flags (
		.clk           (clk),
		.rst           (rst),
		.underflow_evt (fifo_underflow),
		.overflow_evt  (fifo_overflow),
		.clear_req     (err_clear),
		.flags_r       (err_flags)
	);

	// ==========================================
	// status sampling
	always_ff @(posedge clk) begin
		if (rst) begin
			temp_r <= 8'h0;
			loop_r <= 1'b0;
		end else begin
			temp_r <= temp_code;
			loop_r <= loopback_mode;
		end
	end

	// ==========================================
	// outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			gen_disable  <= `GEN_DISABLE_RESET;
			loopback_rst <= 1'b0;
		end else begin
			gen_disable  <= gen_ctrl_r[`GEN_DISABLE_BIT];
			loopback_rst <= soft_rst_r;
		end
	end

	// ==========================================
	// read mux
	always_comb begin
		rdata_nxt = 32'h0;
		case (word_index(haddr))
			`IDX_CLIENT_IDENT:      rdata_nxt = IDENT_WORD;
			`IDX_FEATURE_VECTOR: begin
				// bits 1, 4, 7 forced low whatever the parameter says
				rdata_nxt[9:0] = FEATURE_BITS & ~`FEATURE_ZERO_MASK;
			end
			`IDX_DIE_TEMPERATURE:   rdata_nxt[7:0] = temp_r;
			`IDX_TRAFFIC_GEN_CTRL: begin
				rdata_nxt[3:0] = {loop_r, gen_ctrl_r[2:0]};
			end
			`IDX_LOOPBACK_FIFO_ERR: rdata_nxt[1:0] = err_flags;
			`IDX_LOOPBACK_SOFT_RST: rdata_nxt[0] = soft_rst_r;
			default:                rdata_nxt = 32'h0;
		endcase
	end

	// read data registered at the address phase, stands during data phase
	always_ff @(posedge clk) begin
		if (rst)
			hrdata <= 32'h0;
		else if (take && !hwrite)
			hrdata <= rdata_nxt;
	end

	// ==========================================
	// checks
	// read checks look one edge after the address phase, when hrdata has loaded
	chk_outputs_reset: assert property (
		@(posedge clk)
		rst |=> !loopback_rst && gen_disable == `GEN_DISABLE_RESET
	) else $error("outputs not at reset value");

	chk_gen_disable_follows: assert property (
		@(posedge clk) disable iff (rst)
		##1 gen_disable == $past(gen_ctrl_r[`GEN_DISABLE_BIT])
	) else $error("generator enable lag");

	// write path
	chk_gen_write_lands: assert property (
		@(posedge clk) disable iff (rst)
		wr_pend_r && idx_r == `IDX_TRAFFIC_GEN_CTRL
		|=> gen_ctrl_r[`GEN_DISABLE_BIT] == $past(hwdata[`GEN_DISABLE_BIT])
	) else $error("generator control write lost");

	chk_ctrl_reserved: assert property (
		@(posedge clk) disable iff (rst)
		gen_ctrl_r[0] && gen_ctrl_r[2]
	) else $error("reserved control bits changed");

	chk_lb_write_lands: assert property (
		@(posedge clk) disable iff (rst)
		wr_pend_r && idx_r == `IDX_LOOPBACK_SOFT_RST
		|=> soft_rst_r == $past(hwdata[0])
	) else $error("loopback reset write lost");

	// loopback reset
	chk_lb_reset_holds: assert property (
		@(posedge clk) disable iff (rst)
		soft_rst_r && !(wr_pend_r && idx_r == `IDX_LOOPBACK_SOFT_RST) |=> soft_rst_r
	) else $error("loopback reset dropped");

	chk_lb_reset_out: assert property (
		@(posedge clk) disable iff (rst)
		soft_rst_r |=> loopback_rst
	) else $error("loopback reset not driven");

	chk_lb_release: assert property (
		@(posedge clk) disable iff (rst)
		!soft_rst_r |=> !loopback_rst
	) else $error("loopback reset not released");

	// error flags
	chk_clear_both: assert property (
		@(posedge clk) disable iff (rst)
		err_clear && !fifo_underflow && !fifo_overflow |=> err_flags == 2'h0
	) else $error("error flags not cleared");

	chk_set_beats_clear: assert property (
		@(posedge clk) disable iff (rst)
		err_clear |=> err_flags == $past({fifo_overflow, fifo_underflow})
	) else $error("event lost in clear cycle");

	chk_err_write_kept: assert property (
		@(posedge clk) disable iff (rst)
		wr_pend_r && idx_r == `IDX_LOOPBACK_FIFO_ERR && !hwdata[`ERR_CLEAR_BIT]
		|=> err_flags == $past(err_flags)
	) else $error("error flags changed without clear");

	// bus and read path
	chk_ident_read: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && word_index(haddr) == `IDX_CLIENT_IDENT |=> hrdata == IDENT_WORD
	) else $error("ident read wrong");

	chk_feature_fixed: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && word_index(haddr) == `IDX_FEATURE_VECTOR
		|=> hrdata[7] == 1'b0 && hrdata[1] == 1'b0 && hrdata[31:10] == 22'h0
	) else $error("feature fixed bits wrong");

	chk_feature_family: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && word_index(haddr) == `IDX_FEATURE_VECTOR
		|=> hrdata[0] == FEATURE_BITS[0] && hrdata[2] == FEATURE_BITS[2]
	) else $error("feature family or clock bit wrong");

	chk_feature_flags: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && word_index(haddr) == `IDX_FEATURE_VECTOR
		|=> hrdata[4] == 1'b0 && hrdata[3] == FEATURE_BITS[3]
			&& hrdata[6:5] == FEATURE_BITS[6:5] && hrdata[9:8] == FEATURE_BITS[9:8]
	) else $error("feature presence flags wrong");

	chk_temp_read: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && word_index(haddr) == `IDX_DIE_TEMPERATURE
		|=> hrdata == {24'h0, $past(temp_r)}
	) else $error("temperature read wrong");

	chk_ctrl_read: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && word_index(haddr) == `IDX_TRAFFIC_GEN_CTRL
		|=> hrdata == {28'h0, $past(loop_r), $past(gen_ctrl_r[2:0])}
	) else $error("control read wrong");

	chk_loop_status: assert property (
		@(posedge clk) disable iff (rst)
		loopback_mode ##1 loopback_mode |-> loop_r
	) else $error("loopback status lost");

	chk_err_read: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && word_index(haddr) == `IDX_LOOPBACK_FIFO_ERR
		|=> hrdata == {30'h0, $past(err_flags)}
	) else $error("error register read wrong");

	chk_lb_read: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && word_index(haddr) == `IDX_LOOPBACK_SOFT_RST
		|=> hrdata == {31'h0, $past(soft_rst_r)}
	) else $error("loopback reset read wrong");

	chk_unmapped_zero: assert property (
		@(posedge clk) disable iff (rst)
		take && !hwrite && !reg_mapped(word_index(haddr))
		|=> hrdata == 32'h0
	) else $error("unmapped read not zero");

	chk_hrdata_stands: assert property (
		@(posedge clk) disable iff (rst)
		!(take && !hwrite) |=> $stable(hrdata)
	) else $error("read data changed without a read");

	chk_bus_state_onehot: assert property (
		@(posedge clk) disable iff (rst)
		$onehot(state_r)
	) else $error("bus state not one-hot");

	chk_always_ready: assert property (
		@(posedge clk) disable iff (rst)
		##1 hreadyout && !hresp
	) else $error("slave not ready");

	cov_gen_write: cover property (@(posedge clk) disable iff (rst)
		wr_pend_r && idx_r == `IDX_TRAFFIC_GEN_CTRL);
	cov_err_clear: cover property (@(posedge clk) disable iff (rst) err_clear && err_flags != 2'h0);
	cov_set_on_clear: cover property (@(posedge clk) disable iff (rst) err_clear && fifo_overflow);
	cov_lb_reset: cover property (@(posedge clk) disable iff (rst) soft_rst_r ##1 !soft_rst_r);
	cov_unmapped_read: cover property (@(posedge clk) disable iff (rst)
		take && !hwrite && !reg_mapped(word_index(haddr)));
endmodule // pkt_client_regs

// ==== verif/packet_client_ctrl_regs_bench.sv ====
// self-checking bench for the packet client register bank
// assumes the bank sits alone on an ahb-lite bus and its status inputs share clk
`include "pkt_client_defs.svh"

module packet_client_ctrl_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================
	// clock, reset and ports
	logic        clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  temp_code;
	logic        loopback_mode;
	logic        fifo_underflow;
	logic        fifo_overflow;
	logic        gen_disable;
	logic        loopback_rst;
	int          err_count;
	int          num_checks;

	localparam logic [31:0] ID_WORD = 32'h6465_6d6f; // arbitrary value, four ascii letters
	localparam logic [31:0] A_ID    = {14'h0, `IDX_CLIENT_IDENT, 2'b00};
	localparam logic [31:0] A_FEAT  = {14'h0, `IDX_FEATURE_VECTOR, 2'b00};
	localparam logic [31:0] A_TEMP  = {14'h0, `IDX_DIE_TEMPERATURE, 2'b00};
	localparam logic [31:0] A_GEN   = {14'h0, `IDX_TRAFFIC_GEN_CTRL, 2'b00};
	localparam logic [31:0] A_ERR   = {14'h0, `IDX_LOOPBACK_FIFO_ERR, 2'b00};
	localparam logic [31:0] A_LBR   = {14'h0, `IDX_LOOPBACK_SOFT_RST, 2'b00};

	// the single slave's hreadyout is the bus hready
	pkt_client_regs #(.IDENT_WORD(ID_WORD), .FEATURE_BITS(10'h3ff)) uut (
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.temp_code(temp_code), .loopback_mode(loopback_mode),
		.fifo_underflow(fifo_underflow), .fifo_overflow(fifo_overflow),
		.gen_disable(gen_disable), .loopback_rst(loopback_rst));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// starts on its own edge, so calls may follow each other freely
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'b1, a, wd, d);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask

	// outputs change one edge after the register, look mid-cycle after that
	task automatic settle();
		@(posedge clk);
		@(negedge clk);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		chk({30'h0, gen_disable, loopback_rst}, 32'h0);
		rd_chk(A_ID, ID_WORD);
		rd_chk(A_FEAT, 32'h36d);
		rd_chk(A_GEN, 32'h5);
		rd_chk(A_ERR, 32'h0);
		rd_chk(A_LBR, 32'h0);
		wr(A_ID, 32'h0);
		wr(A_FEAT, 32'h0);
		wr(A_TEMP, 32'hff);
		wr(A_ID + 32'h40, 32'hffff_ffff);
		rd_chk(A_ID, ID_WORD);
		rd_chk(A_FEAT, 32'h36d);
		rd_chk(A_ID + 32'h40, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_gen();
		wr(A_GEN, 32'h2);
		settle();
		chk({31'h0, gen_disable}, 32'h1);
		rd_chk(A_GEN, 32'h7);
		wr(A_GEN, 32'hffff_ffff);
		rd_chk(A_GEN, 32'h7);
		@(posedge clk);
		loopback_mode <= 1'b1;
		rd_chk(A_GEN, 32'hf);
		wr(A_GEN, 32'h0);
		settle();
		chk({31'h0, gen_disable}, 32'h0);
		rd_chk(A_GEN, 32'hd);
		@(posedge clk);
		loopback_mode <= 1'b0;
		$display("test gen done");
	endtask

	task automatic t_err();
		@(posedge clk);
		fifo_underflow <= 1'b1;
		@(posedge clk);
		fifo_underflow <= 1'b0;
		repeat (3) @(posedge clk);
		rd_chk(A_ERR, 32'h1);
		wr(A_ERR, 32'h3);
		rd_chk(A_ERR, 32'h1);
		@(posedge clk);
		fifo_overflow <= 1'b1;
		@(posedge clk);
		fifo_overflow <= 1'b0;
		rd_chk(A_ERR, 32'h3);
		// overflow lands on the clear edge; set must win over clear
		fork
			wr(A_ERR, 32'h4);
			begin
				repeat (2) @(posedge clk);
				fifo_overflow <= 1'b1;
				@(posedge clk);
				fifo_overflow <= 1'b0;
			end
		join
		rd_chk(A_ERR, 32'h2);
		wr(A_ERR, 32'h4);
		rd_chk(A_ERR, 32'h0);
		$display("test err done");
	endtask

	task automatic t_lbr_temp();
		wr(A_LBR, 32'h1);
		settle();
		repeat (10) @(posedge clk);
		@(negedge clk);
		chk({31'h0, loopback_rst}, 32'h1);
		rd_chk(A_LBR, 32'h1);
		wr(A_LBR, 32'h0);
		settle();
		chk({31'h0, loopback_rst}, 32'h0);
		@(posedge clk);
		temp_code <= 8'ha5;
		rd_chk(A_TEMP, 32'ha5);
		$display("test loopback and temperature done");
	endtask

	// reset in mid-run must bring the control, error and loopback reset registers and every output back
	task automatic t_mid_reset();
		wr(A_GEN, 32'h2);
		wr(A_LBR, 32'h1);
		@(posedge clk);
		fifo_underflow <= 1'b1;
		@(posedge clk);
		fifo_underflow <= 1'b0;
		rd_chk(A_ERR, 32'h1);
		chk({30'h0, gen_disable, loopback_rst}, 32'h3);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({30'h0, gen_disable, loopback_rst}, 32'h0);
		chk(hrdata, 32'h0);
		chk({30'h0, hreadyout, hresp}, 32'h2);
		rd_chk(A_GEN, 32'h5);
		rd_chk(A_ERR, 32'h0);
		rd_chk(A_LBR, 32'h0);
		$display("test mid-run reset done");
	endtask

	// ==========================================
	// verdict, main sequence and watchdog
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		err_count = 0;
		num_checks = 0;
		rst = 1'b1;
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'b010;
		{temp_code, loopback_mode, fifo_underflow, fifo_overflow} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_gen();
		t_err();
		t_lbr_temp();
		t_mid_reset();
		finish_test();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		finish_test();
	end
endmodule // packet_client_ctrl_regs_bench
